/* bdc_consts.vh */
// constants of the barometer digital core
`ifndef BDC_CONSTS_VH
`define BDC_CONSTS_VH
`define BDC_I2C_ADDR     7'h62
`define BDC_GCALL_ADDR   7'h00
`define BDC_R_STATUS     5'h00
`define BDC_R_P_MSB      5'h01
`define BDC_R_P_CSB      5'h02
`define BDC_R_P_LSB      5'h03
`define BDC_R_T_MSB      5'h04
`define BDC_R_T_LSB      5'h05
`define BDC_R_FSTAT      5'h06
`define BDC_R_FDATA      5'h07
`define BDC_R_CTRL1      5'h08
`define BDC_R_FSETUP     5'h09
`define BDC_R_INT_EN     5'h0a
`define BDC_R_INT_ROUTE  5'h0b
`define BDC_R_INT_CFG    5'h0c
`define BDC_R_SRC        5'h0d
`define BDC_R_PTGT_MSB   5'h0e
`define BDC_R_PTGT_LSB   5'h0f
`define BDC_R_PWND_MSB   5'h10
`define BDC_R_PWND_LSB   5'h11
`define BDC_R_TTGT       5'h12
`define BDC_R_TWND       5'h13
`define BDC_R_SYSMOD     5'h14
`define BDC_CTRL_SBY     0
`define BDC_CTRL_OST     1
`define BDC_CTRL_EXP_HI  7
`define BDC_CTRL_EXP_LO  4
`define BDC_FS_MODE_HI   7
`define BDC_FS_MODE_LO   6
`define BDC_FS_WMK_HI    5
`define BDC_FS_WMK_LO    0
`define BDC_FMODE_OFF    2'h0
`define BDC_FMODE_CIRC   2'h1
`define BDC_FMODE_STOP   2'h2
`define BDC_RST_BYTE     8'h00
`define BDC_CLK_HZ       40000000
`define BDC_ACQ_UNIT_S   1
`define BDC_FIFO_DEPTH   32
`define BDC_FDATA_LAST   3'h4
`endif

/* bdc_core.v */
// barometer digital core: i2c client, registers, acquisition, fifo, events
`timescale 1ns/1ps
`default_nettype none
`include "bdc_consts.vh"
module bdc_core #(
	parameter TICKS_PER_SEC = `BDC_CLK_HZ * `BDC_ACQ_UNIT_S,
	parameter DEPTH         = `BDC_FIFO_DEPTH
) (
	input  wire        clk,        // 40 MHz core clock
	input  wire        rst_n,      // synchronous reset, active low
	input  wire        scl_i,      // i2c clock pin level
	input  wire        sda_i,      // i2c data pin level
	output wire        sda_o,      // sda drive value, always low
	output wire        sda_oe,     // sda pulled low while high
	input  wire        meas_valid, // analog front end result strobe
	input  wire [19:0] meas_pres,  // compensated pressure, pascals
	input  wire [15:0] meas_temp,  // temperature
	output wire        meas_req,   // start one acquisition, pulse
	output wire        analog_en,  // analog subsystem power
	output wire [15:0] comp_temp,  // temperature for pressure compensation
	output wire        irq_a_o,    // interrupt pin a drive value
	output wire        irq_a_oe,   // interrupt pin a drive enable
	output wire        irq_b_o,    // interrupt pin b drive value
	output wire        irq_b_oe,   // interrupt pin b drive enable
	output wire        bus_busy    // between start and stop
);
	localparam S_IDLE = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_ACKA = 3'h2;
	localparam S_WR   = 3'h3;
	localparam S_ACKW = 3'h4;
	localparam S_RD   = 3'h5;
	localparam S_ACKR = 3'h6;
	localparam S_IGN  = 3'h7;
	localparam [25:0] TICK_LAST = TICKS_PER_SEC - 1;
	localparam [5:0]  DEPTH_CNT = DEPTH;

	// pin synchronisers and edge detection
	reg scl_m_q, scl_s_q, scl_q, sda_m_q, sda_s_q, sda_q;
	always @(posedge clk) begin
		if (!rst_n) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_q   <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_q   <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			scl_q   <= scl_s_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_q   <= sda_s_q;
		end
	end
	wire scl_rise = scl_s_q & ~scl_q;
	wire scl_fall = ~scl_s_q & scl_q;
	wire i2c_start = scl_s_q & scl_q & sda_q & ~sda_s_q;
	wire i2c_stop  = scl_s_q & scl_q & ~sda_q & sda_s_q;

	// register state
	reg  [7:0]  ctrl_q, fsetup_q, int_en_q, route_q, int_cfg_q, src_q, ttgt_q, twnd_q;
	reg  [15:0] ptgt_q, pwnd_q;
	reg  [19:0] pres_q;
	reg  [15:0] temp_q;
	reg         dr_q, ow_q, ovf_q, shot_q;
	reg  [5:0]  cnt_q;
	reg  [4:0]  wp_q, rp_q;
	reg  [2:0]  fb_q;
	reg  [35:0] fifo_mem [0:DEPTH-1];
	wire [35:0] head = fifo_mem[rp_q];
	wire [5:0]  wmk = fsetup_q[`BDC_FS_WMK_HI:`BDC_FS_WMK_LO];
	wire [1:0]  fmode = fsetup_q[`BDC_FS_MODE_HI:`BDC_FS_MODE_LO];
	wire        wmk_hit = (wmk != 6'h00) && (cnt_q >= wmk);

	// i2c client
	reg [2:0] st_q;
	reg [3:0] bit_q;
	reg [7:0] sh_q, tx_q, rd_data;
	reg [4:0] ptr_q, rd_addr_q, wr_addr_q;
	reg [7:0] wr_data_q;
	reg       rw_q, first_q, drv_q, busy_q, rd_pulse_q, wr_pulse_q;

	always @* begin
		case (ptr_q)
		`BDC_R_STATUS:    rd_data = {6'h00, ow_q, dr_q};
		`BDC_R_P_MSB:     rd_data = pres_q[19:12];
		`BDC_R_P_CSB:     rd_data = pres_q[11:4];
		`BDC_R_P_LSB:     rd_data = {pres_q[3:0], 4'h0};
		`BDC_R_T_MSB:     rd_data = temp_q[15:8];
		`BDC_R_T_LSB:     rd_data = temp_q[7:0];
		`BDC_R_FSTAT:     rd_data = {ovf_q, wmk_hit, cnt_q};
		`BDC_R_FDATA: begin
			case (fb_q)
			3'h0:    rd_data = head[35:28];
			3'h1:    rd_data = head[27:20];
			3'h2:    rd_data = {head[19:16], 4'h0};
			3'h3:    rd_data = head[15:8];
			default: rd_data = head[7:0];
			endcase
		end
		`BDC_R_CTRL1:     rd_data = ctrl_q;
		`BDC_R_FSETUP:    rd_data = fsetup_q;
		`BDC_R_INT_EN:    rd_data = int_en_q;
		`BDC_R_INT_ROUTE: rd_data = route_q;
		`BDC_R_INT_CFG:   rd_data = int_cfg_q;
		`BDC_R_SRC:       rd_data = src_q;
		`BDC_R_PTGT_MSB:  rd_data = ptgt_q[15:8];
		`BDC_R_PTGT_LSB:  rd_data = ptgt_q[7:0];
		`BDC_R_PWND_MSB:  rd_data = pwnd_q[15:8];
		`BDC_R_PWND_LSB:  rd_data = pwnd_q[7:0];
		`BDC_R_TTGT:      rd_data = ttgt_q;
		`BDC_R_TWND:      rd_data = twnd_q;
		`BDC_R_SYSMOD:    rd_data = {7'h00, analog_en};
		default:          rd_data = `BDC_RST_BYTE;
		endcase
	end

	// the fifo data port keeps its address so a burst drains entries
	wire [4:0] ptr_next = (ptr_q == `BDC_R_FDATA) ? ptr_q : ptr_q + 5'h01;

	always @(posedge clk) begin
		if (!rst_n) begin
			st_q       <= S_IDLE;
			bit_q      <= 4'h0;
			sh_q       <= 8'h00;
			tx_q       <= 8'h00;
			ptr_q      <= 5'h00;
			rd_addr_q  <= 5'h00;
			wr_addr_q  <= 5'h00;
			wr_data_q  <= 8'h00;
			rw_q       <= 1'b0;
			first_q    <= 1'b0;
			drv_q      <= 1'b0;
			busy_q     <= 1'b0;
			rd_pulse_q <= 1'b0;
			wr_pulse_q <= 1'b0;
		end else begin
			rd_pulse_q <= 1'b0;
			wr_pulse_q <= 1'b0;
			if (i2c_start) begin
				// a repeated start lands here too and keeps the pointer
				st_q    <= S_ADDR;
				bit_q   <= 4'h0;
				drv_q   <= 1'b0;
				first_q <= 1'b1;
				busy_q  <= 1'b1;
			end else if (i2c_stop) begin
				st_q   <= S_IDLE;
				drv_q  <= 1'b0;
				busy_q <= 1'b0;
			end else if (scl_rise) begin
				// nothing here waits on a timer: a held scl just delays this edge
				if (st_q == S_ADDR || st_q == S_WR) begin
					sh_q  <= {sh_q[6:0], sda_s_q};
					bit_q <= bit_q + 4'h1;
				end else if (st_q == S_ACKR && sda_s_q)
					st_q <= S_IGN;
			end else if (scl_fall) begin
				case (st_q)
				S_ADDR: begin
					if (bit_q == 4'h8) begin
						bit_q <= 4'h0;
						if (sh_q[7:1] == `BDC_I2C_ADDR && sh_q[7:1] != `BDC_GCALL_ADDR) begin
							drv_q <= 1'b1;
							rw_q  <= sh_q[0];
							st_q  <= S_ACKA;
						end else
							st_q <= S_IGN;
					end
				end
				S_ACKA, S_ACKR: begin
					if (st_q == S_ACKA && !rw_q) begin
						drv_q <= 1'b0;
						st_q  <= S_WR;
						bit_q <= 4'h0;
					end else begin
						tx_q       <= rd_data;
						drv_q      <= ~rd_data[7];
						bit_q      <= 4'h1;
						st_q       <= S_RD;
						rd_pulse_q <= 1'b1;
						rd_addr_q  <= ptr_q;
						ptr_q      <= ptr_next;
					end
				end
				S_WR: begin
					if (bit_q == 4'h8) begin
						bit_q <= 4'h0;
						drv_q <= 1'b1;
						st_q  <= S_ACKW;
						if (first_q) begin
							ptr_q   <= sh_q[4:0];
							first_q <= 1'b0;
						end else begin
							wr_pulse_q <= 1'b1;
							wr_addr_q  <= ptr_q;
							wr_data_q  <= sh_q;
							ptr_q      <= ptr_next;
						end
					end
				end
				S_ACKW: begin
					drv_q <= 1'b0;
					st_q  <= S_WR;
				end
				S_RD: begin
					if (bit_q == 4'h8) begin
						drv_q <= 1'b0;
						st_q  <= S_ACKR;
					end else begin
						drv_q <= ~tx_q[6];
						tx_q  <= {tx_q[6:0], 1'b0};
						bit_q <= bit_q + 4'h1;
					end
				end
				default: drv_q <= 1'b0;
				endcase
			end
		end
	end
	// only sda is ever driven; scl has no output so low phases are never stretched
	assign sda_o    = 1'b0;
	assign sda_oe   = drv_q;
	assign bus_busy = busy_q;

	wire clr_src = rd_pulse_q && rd_addr_q == `BDC_R_SRC;
	wire clr_dr  = rd_pulse_q && rd_addr_q == `BDC_R_T_LSB;
	wire clr_ovf = rd_pulse_q && rd_addr_q == `BDC_R_FSTAT;
	wire fd_rd   = rd_pulse_q && rd_addr_q == `BDC_R_FDATA;

	// acquisition sequencing
	reg  [25:0] sub_q;
	reg  [15:0] secs_q;
	reg         kick_q, busy_acq_q, req_q, sby_prev_q;
	wire        sby = ctrl_q[`BDC_CTRL_SBY];
	wire [3:0]  expo = ctrl_q[`BDC_CTRL_EXP_HI:`BDC_CTRL_EXP_LO];
	wire [15:0] per_last = (16'h0001 << expo) - 16'h0001;
	wire        tick = sub_q == TICK_LAST;
	wire        smp_v = meas_valid && busy_acq_q;
	wire        ost_wr = wr_pulse_q && wr_addr_q == `BDC_R_CTRL1 && wr_data_q[`BDC_CTRL_OST];

	assign analog_en = sby | shot_q;
	assign meas_req  = req_q;
	assign comp_temp = temp_q;

	always @(posedge clk) begin
		if (!rst_n) begin
			sub_q      <= 26'h0;
			secs_q     <= 16'h0;
			kick_q     <= 1'b0;
			busy_acq_q <= 1'b0;
			req_q      <= 1'b0;
			sby_prev_q <= 1'b0;
			shot_q     <= 1'b0;
		end else begin
			sby_prev_q <= sby;
			req_q      <= 1'b0;
			if (!sby) begin
				sub_q  <= 26'h0;
				secs_q <= 16'h0;
			end else begin
				sub_q <= tick ? 26'h0 : sub_q + 26'h1;
				if (tick)
					secs_q <= (secs_q >= per_last) ? 16'h0 : secs_q + 16'h1;
			end
			if (ost_wr)
				shot_q <= 1'b1;
			else if (smp_v)
				shot_q <= 1'b0;
			if ((sby && !sby_prev_q) || ost_wr || (sby && tick && secs_q >= per_last))
				kick_q <= 1'b1;
			else if (req_q)
				kick_q <= 1'b0;
			// a kick during a conversion waits rather than restarting it
			if (kick_q && analog_en && !busy_acq_q && !req_q) begin
				req_q      <= 1'b1;
				busy_acq_q <= 1'b1;
			end else if (smp_v || !analog_en)
				busy_acq_q <= 1'b0;
		end
	end

	// software registers, data latch and status
	always @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q    <= `BDC_RST_BYTE;
			fsetup_q  <= `BDC_RST_BYTE;
			int_en_q  <= `BDC_RST_BYTE;
			route_q   <= `BDC_RST_BYTE;
			int_cfg_q <= `BDC_RST_BYTE;
			ttgt_q    <= `BDC_RST_BYTE;
			twnd_q    <= `BDC_RST_BYTE;
			ptgt_q    <= 16'h0000;
			pwnd_q    <= 16'h0000;
			pres_q    <= 20'h00000;
			temp_q    <= 16'h0000;
			dr_q      <= 1'b0;
			ow_q      <= 1'b0;
		end else begin
			if (wr_pulse_q) begin
				case (wr_addr_q)
				`BDC_R_CTRL1:     ctrl_q <= wr_data_q;
				`BDC_R_FSETUP:    fsetup_q <= wr_data_q;
				`BDC_R_INT_EN:    int_en_q <= wr_data_q;
				`BDC_R_INT_ROUTE: route_q <= wr_data_q;
				`BDC_R_INT_CFG:   int_cfg_q <= wr_data_q;
				`BDC_R_PTGT_MSB:  ptgt_q[15:8] <= wr_data_q;
				`BDC_R_PTGT_LSB:  ptgt_q[7:0] <= wr_data_q;
				`BDC_R_PWND_MSB:  pwnd_q[15:8] <= wr_data_q;
				`BDC_R_PWND_LSB:  pwnd_q[7:0] <= wr_data_q;
				`BDC_R_TTGT:      ttgt_q <= wr_data_q;
				`BDC_R_TWND:      twnd_q <= wr_data_q;
				default:          ctrl_q <= ctrl_q;
				endcase
			end
			if (smp_v && shot_q)
				ctrl_q[`BDC_CTRL_OST] <= 1'b0;
			if (smp_v) begin
				pres_q <= meas_pres;
				temp_q <= meas_temp;
			end
			dr_q <= smp_v | (dr_q & ~clr_dr);
			ow_q <= (smp_v & dr_q & ~clr_dr) | (ow_q & ~clr_dr);
		end
	end

	// sample fifo: circular mode drops the oldest entry, stop mode the newest
	wire push   = smp_v && fmode != `BDC_FMODE_OFF;
	wire pop    = fd_rd && fb_q == `BDC_FDATA_LAST && cnt_q != 6'h00;
	wire full   = cnt_q == DEPTH_CNT && !pop;
	wire wr_ok  = push && (!full || fmode == `BDC_FMODE_CIRC);
	wire rp_adv = pop || (push && full && fmode == `BDC_FMODE_CIRC);
	always @(posedge clk) begin
		if (wr_ok)
			fifo_mem[wp_q] <= {meas_pres, meas_temp};
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			wp_q  <= 5'h00;
			rp_q  <= 5'h00;
			cnt_q <= 6'h00;
			fb_q  <= 3'h0;
			ovf_q <= 1'b0;
		end else begin
			if (wr_ok)
				wp_q <= wp_q + 5'h01;
			if (rp_adv)
				rp_q <= rp_q + 5'h01;
			if (wr_ok && !full && !pop)
				cnt_q <= cnt_q + 6'h01;
			else if (pop && !push)
				cnt_q <= cnt_q - 6'h01;
			if (fd_rd)
				fb_q <= (fb_q == `BDC_FDATA_LAST) ? 3'h0 : fb_q + 3'h1;
			ovf_q <= (push && full) | (ovf_q & ~clr_ovf);
		end
	end

	// event detection
	wire p_thr, p_win, p_chg, t_thr, t_win, t_chg;
	bdc_limit_chk #(.W(16)) u_pchk (
		.clk     (clk),
		.rst_n   (rst_n),
		.smp_v   (smp_v),
		.cur     (meas_pres[19:4]),
		.tgt     (ptgt_q),
		.win     (pwnd_q),
		.thr_hit (p_thr),
		.in_win  (p_win),
		.chg_hit (p_chg)
	);
	bdc_limit_chk #(.W(8)) u_tchk (
		.clk     (clk),
		.rst_n   (rst_n),
		.smp_v   (smp_v),
		.cur     (meas_temp[15:8]),
		.tgt     (ttgt_q),
		.win     (twnd_q),
		.thr_hit (t_thr),
		.in_win  (t_win),
		.chg_hit (t_chg)
	);

	// sticky sources; a new event in the clearing cycle survives the clear
	wire [7:0] src_set = {t_chg, p_chg, t_win, t_thr, p_win, p_thr,
		ovf_q | wmk_hit, dr_q | ow_q};
	always @(posedge clk) begin
		if (!rst_n)
			src_q <= 8'h00;
		else
			src_q <= src_set | (src_q & ~{8{clr_src}});
	end

	// interrupt pins: route bit set sends a source to pin a, clear to pin b
	wire [7:0] act_src = src_q & int_en_q;
	wire [1:0] act = {|(act_src & ~route_q), |(act_src & route_q)};
	reg  [1:0] pin_o_q, pin_oe_q;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
			wire pol = int_cfg_q[2*gi];
			wire od  = int_cfg_q[2*gi+1];
			wire lvl = pol ? act[gi] : ~act[gi];
			always @(posedge clk) begin
				if (!rst_n) begin
					pin_o_q[gi]  <= 1'b0;
					pin_oe_q[gi] <= 1'b1;
				end else begin
					pin_o_q[gi]  <= od ? 1'b0 : lvl;
					pin_oe_q[gi] <= od ? ~lvl : 1'b1;
				end
			end
		end
	endgenerate
	assign irq_a_o  = pin_o_q[0];
	assign irq_a_oe = pin_oe_q[0];
	assign irq_b_o  = pin_o_q[1];
	assign irq_b_oe = pin_oe_q[1];
endmodule // bdc_core
`default_nettype wire

/* bdc_core_monitor.sv */
// concurrent checks on the ports of the barometer digital core
`timescale 1ns/1ps
`default_nettype none
module bdc_core_monitor #(
	parameter TICKS_PER_SEC = 20,
	parameter DEPTH         = 32
) (
	input wire logic        clk,        // core clock
	input wire logic        rst_n,      // synchronous reset, active low
	input wire logic        scl_i,      // scl pin level
	input wire logic        sda_i,      // sda pin level
	input wire logic        sda_o,      // sda drive value
	input wire logic        sda_oe,     // sda pull enable
	input wire logic        meas_valid, // front end result strobe
	input wire logic [15:0] meas_temp,  // front end temperature
	input wire logic        meas_req,   // acquisition request
	input wire logic        analog_en,  // analog power
	input wire logic [15:0] comp_temp,  // temperature for compensation
	input wire logic        bus_busy    // start seen, stop not yet
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// the synchronisers delay pin edges by a few cycles, hence the ranges
	chk_start_busy: assert property ($fell(sda_i) && scl_i |-> ##[1:6] bus_busy)
		else $error("start not seen as busy");
	chk_busy_rise: assert property ($rose(bus_busy) |-> !sda_i)
		else $error("busy rose without a start");
	chk_stop_idle: assert property ($rose(sda_i) && scl_i |-> ##[1:6] !bus_busy)
		else $error("stop did not end busy");
	chk_idle_quiet: assert property (!bus_busy [*4] |-> !sda_oe)
		else $error("sda pulled while idle");
	chk_sda_never_high: assert property (sda_o == 1'b0)
		else $error("sda driven high");
	chk_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_i))
		else $error("sda changed while scl high");
	chk_req_pulse: assert property (meas_req |=> !meas_req)
		else $error("request longer than one cycle");
	chk_req_powered: assert property (meas_req |-> analog_en)
		else $error("acquisition with analog off");
	chk_temp_comp: assert property ($changed(comp_temp) |->
		$past(meas_valid) && comp_temp == $past(meas_temp))
		else $error("compensation temperature wrong");
	cov_ack: cover property ($rose(sda_oe));
	cov_req: cover property (meas_req);
	cov_stop: cover property ($fell(bus_busy));
endmodule // bdc_core_monitor
bind bdc_core bdc_core_monitor #(.TICKS_PER_SEC(TICKS_PER_SEC), .DEPTH(DEPTH)) i_bdc_core_monitor (
	.clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
	.meas_valid(meas_valid), .meas_temp(meas_temp), .meas_req(meas_req),
	.analog_en(analog_en), .comp_temp(comp_temp), .bus_busy(bus_busy));
`default_nettype wire

/* bdc_i2c_host.sv */
// i2c host model pulling scl and sda low as open-drain lines
`timescale 1ns/1ps
`default_nettype none
module bdc_i2c_host (
	input  wire logic sda,     // sda wire level
	output var  logic scl_low, // pull scl low
	output var  logic sda_low  // pull sda low
);
	integer pause = 0;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// also a repeated start: from idle the first two steps change nothing
	task automatic start;
		sda_low = 1'b0;
		#50 scl_low = 1'b0;
		#100 sda_low = 1'b1;
		#100 scl_low = 1'b1;
		#100;
	endtask
	task automatic stop;
		sda_low = 1'b1;
		#50 scl_low = 1'b0;
		#50 sda_low = 1'b0;
		#150;
	endtask
	task automatic bit_x(input logic b, output logic r);
		sda_low = ~b;
		#50 scl_low = 1'b0;
		#50 r = sda;
		#50 scl_low = 1'b1;
		#50;
	endtask
	// a nonzero pause keeps scl low before the byte to stall the device
	task automatic xfer(input logic [7:0] d, input logic ak_in, output logic [7:0] r,
		output logic ak);
		integer i;
		#(pause);
		for (i = 7; i >= 0; i--) bit_x(d[i], r[i]);
		bit_x(ak_in, ak);
	endtask
endmodule // bdc_i2c_host
`default_nettype wire

/* bdc_limit_chk.v */
// target, window and change detector for one measured quantity
`timescale 1ns/1ps
`default_nettype none
module bdc_limit_chk #(
	parameter W = 16
) (
	input  wire         clk,     // core clock
	input  wire         rst_n,   // synchronous reset, active low
	input  wire         smp_v,   // new sample strobe
	input  wire [W-1:0] cur,     // new sample
	input  wire [W-1:0] tgt,     // target
	input  wire [W-1:0] win,     // window
	output reg          thr_hit, // target or window edge reached, pulse
	output reg          in_win,  // sample inside target +/- window, pulse
	output reg          chg_hit  // step from previous sample above window, pulse
);
	reg  [W-1:0] prev_q;
	reg          have_q;
	wire [W:0]   c  = {1'b0, cur};
	wire [W:0]   p  = {1'b0, prev_q};
	wire [W:0]   hi = {1'b0, tgt} + {1'b0, win};
	wire [W:0]   lo = (tgt > win) ? {1'b0, tgt - win} : {(W+1){1'b0}};
	wire [W:0]   dif = (c > p) ? c - p : p - c;
	wire         wz = (win == {W{1'b0}});

	// reaching counts too, so a sample landing exactly on the level fires
	function crossed;
		input [W:0] a;
		input [W:0] b;
		input [W:0] lvl;
		input       hv;
		begin
			crossed = (b == lvl) || (hv && ((a < lvl && b > lvl) || (a > lvl && b < lvl)));
		end
	endfunction

	always @(posedge clk) begin
		if (!rst_n) begin
			prev_q  <= {W{1'b0}};
			have_q  <= 1'b0;
			thr_hit <= 1'b0;
			in_win  <= 1'b0;
			chg_hit <= 1'b0;
		end else begin
			thr_hit <= smp_v && (crossed(p, c, {1'b0, tgt}, have_q) ||
				(!wz && (crossed(p, c, hi, have_q) || crossed(p, c, lo, have_q))));
			in_win  <= smp_v && !wz && c >= lo && c <= hi;
			chg_hit <= smp_v && have_q && dif > {1'b0, win};
			if (smp_v) begin
				prev_q <= cur;
				have_q <= 1'b1;
			end
		end
	end
endmodule // bdc_limit_chk
`default_nettype wire

/* tb_bdc_core.sv */
// self-checking bench for the barometer digital core
`timescale 1ns/1ps
`default_nettype none
module tb_bdc_core;
	logic        clk        = 1'b0;
	logic        rst_n      = 1'b0;
	logic        meas_valid = 1'b0;
	logic [19:0] meas_pres  = 20'h00000;
	logic [15:0] meas_temp  = 16'h0000;
	wire         scl_low, sda_low, sda_o, sda_oe, meas_req, analog_en, bus_busy;
	wire  [15:0] comp_temp;
	wire         irq_a_o, irq_a_oe, irq_b_o;
	wire         scl = ~scl_low;
	wire         sda = ~(sda_low | sda_oe);
	integer      errors = 0, n_tests = 0, cyc = 0, fe_cnt = 0, n_req = 0;
	always #12.5 clk = ~clk;
	bdc_core #(.TICKS_PER_SEC(20), .DEPTH(32)) i_bdc_core (
		.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.meas_valid(meas_valid), .meas_pres(meas_pres), .meas_temp(meas_temp),
		.meas_req(meas_req), .analog_en(analog_en), .comp_temp(comp_temp),
		.irq_a_o(irq_a_o), .irq_a_oe(irq_a_oe), .irq_b_o(irq_b_o), .irq_b_oe(),
		.bus_busy(bus_busy));
	bdc_i2c_host i_bdc_i2c_host (.sda(sda), .scl_low(scl_low), .sda_low(sda_low));
	// front end answers each request six cycles later
	always @(posedge clk) begin
		#1;
		cyc++;
		meas_valid = (fe_cnt == 1);
		if (fe_cnt != 0) fe_cnt--;
		if (meas_req) begin
			fe_cnt = 6;
			n_req++;
		end
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end
	task automatic close_out;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] b [3];
		logic [7:0] r;
		logic       k;
		integer     i;
		b = '{8'hc4, a, d};
		i_bdc_i2c_host.start();
		for (i = 0; i < 3; i++) begin
			i_bdc_i2c_host.xfer(b[i], 1'b1, r, k);
			cmp_bit(k, 1'b0);
		end
		i_bdc_i2c_host.stop();
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		logic       k;
		i_bdc_i2c_host.start();
		i_bdc_i2c_host.xfer(8'hc4, 1'b1, r, k);
		i_bdc_i2c_host.xfer(a, 1'b1, r, k);
		i_bdc_i2c_host.start();
		i_bdc_i2c_host.xfer(8'hc5, 1'b1, r, k);
		cmp_bit(k, 1'b0);
		i_bdc_i2c_host.xfer(8'hff, 1'b1, d, k);
		i_bdc_i2c_host.stop();
	endtask
	task automatic t_addr;
		logic [7:0] bad [2];
		logic [7:0] r;
		logic       k;
		integer     i;
		bad = '{8'h00, 8'hc6};
		for (i = 0; i < 2; i++) begin
			i_bdc_i2c_host.start();
			cmp_bit(bus_busy, 1'b1);
			i_bdc_i2c_host.xfer(bad[i], 1'b1, r, k);
			cmp_bit(k, 1'b1);
			i_bdc_i2c_host.stop();
			cmp_bit(bus_busy, 1'b0);
		end
	endtask
	task automatic t_pause_rw;
		logic [7:0] d;
		reg_wr(8'h12, 8'ha5);
		i_bdc_i2c_host.pause = 2000;
		reg_rd(8'h12, d);
		i_bdc_i2c_host.pause = 0;
		cmp_byte(d, 8'ha5);
	endtask
	task automatic t_one_shot;
		logic [7:0] exp [6];
		logic [7:0] d;
		integer     i;
		exp = '{8'h00, 8'h18, 8'h6a, 8'h50, 8'h12, 8'h34};
		meas_pres = 20'h186a5;
		meas_temp = 16'h1234;
		n_req = 0;
		// target equals the coming sample, data-ready and threshold go to pin a, active high
		reg_wr(8'h0e, 8'h18);
		reg_wr(8'h0f, 8'h6a);
		reg_wr(8'h0c, 8'h01);
		reg_wr(8'h0b, 8'h05);
		reg_wr(8'h0a, 8'h05);
		reg_wr(8'h08, 8'h02);
		for (i = 0; i < 300 && analog_en !== 1'b0; i++) @(posedge clk);
		cmp_bit(analog_en, 1'b0);
		cmp_byte(n_req[7:0], 8'h01);
		cmp_byte(comp_temp[15:8], 8'h12);
		cmp_byte(comp_temp[7:0], 8'h34);
		cmp_bit(irq_a_o, 1'b1);
		cmp_bit(irq_a_oe, 1'b1);
		cmp_bit(irq_b_o, 1'b1);
		for (i = 1; i < 6; i++) begin
			reg_rd(i[7:0], d);
			cmp_byte(d, exp[i]);
		end
		reg_rd(8'h0d, d);
		cmp_byte(d, 8'h05);
		cmp_bit(irq_a_o, 1'b0);
		reg_rd(8'h08, d);
		cmp_byte(d, 8'h00);
	endtask
	task automatic t_active;
		logic [7:0] d;
		integer     m;
		meas_pres = 20'h0abcd;
		n_req = 0;
		reg_wr(8'h08, 8'h01);
		cmp_bit(analog_en, 1'b1);
		repeat (100) @(posedge clk);
		cmp_bit(n_req >= 4 && n_req <= 7, 1'b1);
		reg_wr(8'h08, 8'h00);
		m = n_req;
		repeat (60) @(posedge clk);
		cmp_bit(n_req == m, 1'b1);
		cmp_bit(analog_en, 1'b0);
		reg_rd(8'h01, d);
		cmp_byte(d, 8'h0a);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (5) @(posedge clk);
		#2;
		cmp_bit(bus_busy, 1'b0);
		cmp_bit(analog_en, 1'b0);
		t_addr();
		t_pause_rw();
		t_one_shot();
		t_active();
		close_out();
	end
endmodule // tb_bdc_core
`default_nettype wire
